// >>> inc/pcca_pkg.sv
package pcca_pkg;
  // ==========================================================
  // array geometry
  localparam int unsigned COL_W = 11;
  localparam int unsigned STG_W = 10;
  localparam int unsigned ROW_W = 10;
  localparam int unsigned NUM_STG = 640;
  localparam logic [COL_W-1:0] COL_LAST = 11'h4FF;
  localparam logic [ROW_W-1:0] ROW_LAST = 10'h3FF;
  localparam logic [STG_W-1:0] SUB_MAX_STG = 10'h13F;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CAL_TIME_NS = 3500;
  localparam int unsigned CAL_CYC = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] CAL_LAST = 7'(CAL_CYC - 1);
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_XSTART = 8'h04;
  localparam logic [7:0] OFS_XSTOP = 8'h08;
  localparam logic [7:0] OFS_YSTART = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ==========================================================
  // control fields
  localparam int unsigned CTRL_SUB = 0;
  localparam int unsigned CTRL_SWAP1 = 1;
  localparam int unsigned CTRL_SWAP2 = 2;
  localparam int unsigned CTRL_KNEE = 3;
  localparam int unsigned CTRL_EXTRST = 5;
  localparam int unsigned CTRL_W = 6;
  // status fields
  localparam int unsigned STS_STATE = 0;
  localparam int unsigned STS_INTEG = 2;
  localparam int unsigned STS_STAGE = 4;
  localparam int unsigned STS_ROW = 16;
  // ==========================================================
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [COL_W-1:0] XSTART_RST = 11'h000;
  localparam logic [COL_W-1:0] XSTOP_RST = 11'h4FF;
  localparam logic [ROW_W-1:0] YSTART_RST = 10'h000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CALIB,
    ST_SYNC,
    ST_SHIFT
  } pcca_state_t;
endpackage

// >>> rtl/pcca_core.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - sequencer makes pixel controls; start/stop strobes bound integration
// - calibration during blanking before row pixels
// - one pixel per system clock after blanking
// - pointer selects column pair, half clock rate
// - even columns bus A, odd bus B
// - both buses merged into one stream
// - sync path alone loads decoder into pointer
// - decoder loads single one into pointer
// - pointer shifts from start after sync release
// - no sub-sampling: advance one stage
// - sub-sampling: advance two stages, XXOOXXOO
// - first swap gives XOXOXOXO
// - second swap gives OXOXOXOX
// - both swaps give OOXXOOXX
// - sub-sample start even, at most 638
// - knee bits program multislope level circuit
// - external level bit disconnects internal generator
// - row-start loads row, row clock loads column
module pcca_core (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ss_start_i,
  input wire logic ss_stop_i,
  input wire logic row_start_i,
  input wire logic row_clk_i,
  output logic pixel_reset_o,
  output logic pixel_sample_o,
  output logic pixel_hold_o,
  output logic calib_o,
  output logic col_sync_o,
  output logic pixel_valid_o,
  output logic [pcca_pkg::COL_W-1:0] pixel_col_o,
  output logic bus_sel_o,
  output logic [pcca_pkg::ROW_W-1:0] row_ptr_o,
  output logic [1:0] multislope_level_select_o,
  output logic external_reset_level_select_o,
  output logic multislope_gen_connect_o
);
  import pcca_pkg::*;

  // ==========================================================
  // functions
  // decoder output: a single one at the start stage
  function automatic logic [NUM_STG-1:0] pcca_onehot(input logic [STG_W-1:0] stg);
    pcca_onehot = {{(NUM_STG-1){1'b0}}, 1'b1} << stg;
  endfunction

  // column read at a pointer stage: the pair base plus an offset; in sub-sampling the group of
  // four starts at the pointer, so an odd start stage keeps its window instead of slipping back
  function automatic logic [COL_W-1:0] pcca_map_col(input logic [STG_W-1:0] stg, input logic ph,
                                                    input logic sub, input logic sw1, input logic sw2);
    logic [1:0] ofs;
    ofs = {1'b0, ph};
    if (sub) begin
      case ({sw2, sw1, ph})
        3'b010: ofs = 2'h0;
        3'b011: ofs = 2'h2;
        3'b100: ofs = 2'h1;
        3'b101: ofs = 2'h3;
        3'b110: ofs = 2'h2;
        3'b111: ofs = 2'h3;
        default: ofs = {1'b0, ph};
      endcase
    end
    pcca_map_col = {stg, 1'b0} + {9'h000, ofs};
  endfunction

  // the pointer moves one stage per shift, or two when sub-sampling skips a pair
  function automatic logic [NUM_STG-1:0] pcca_adv_ptr(input logic [NUM_STG-1:0] ptr, input logic sub);
    pcca_adv_ptr = sub ? (ptr << 2) : (ptr << 1);
  endfunction

  // ==========================================================
  // registers
  logic [CTRL_W-1:0] ctrl_r;
  logic [COL_W-1:0] xstart_r;
  logic [COL_W-1:0] xstop_r;
  logic [ROW_W-1:0] ystart_r;
  pcca_state_t state_r;
  pcca_state_t state_nxt;
  logic [6:0] cal_cnt_r;
  logic [NUM_STG-1:0] ptr_r;
  logic [NUM_STG-1:0] ptr_nxt;
  logic [STG_W-1:0] stage_r;
  logic [STG_W-1:0] stage_nxt;
  // clock phase within a pointer stage
  logic phase_r;
  logic integ_r;
  logic pix_reset_r;
  logic pix_hold_r;
  logic pix_valid_r;
  logic [COL_W-1:0] pix_col_r;
  logic [ROW_W-1:0] row_r;

  // ==========================================================
  // bus decode
  wire logic acc = psel_i & penable_i;
  wire logic hit_ctrl = (paddr_i == OFS_CTRL);
  wire logic hit_xstart = (paddr_i == OFS_XSTART);
  wire logic hit_xstop = (paddr_i == OFS_XSTOP);
  wire logic hit_ystart = (paddr_i == OFS_YSTART);
  wire logic hit_status = (paddr_i == OFS_STATUS);
  wire logic mapped = hit_ctrl | hit_xstart | hit_xstop | hit_ystart | hit_status;
  wire logic wr = acc & pwrite_i & mapped;

  wire logic sub = ctrl_r[CTRL_SUB];
  wire logic sw1 = ctrl_r[CTRL_SWAP1];
  wire logic sw2 = ctrl_r[CTRL_SWAP2];

  // the one-hot pointer feeds no column logic, columns come from stage_r; status shows whether it holds a stage
  wire logic ptr_live = |ptr_r;
  // status word: state, integrating, pointer live, stage, row
  wire logic [31:0] status_w = {6'h00, row_r, 2'h0, stage_r, ptr_live, integ_r, state_r};

  // zero wait states: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o = hit_ctrl ? {26'h0, ctrl_r} :
                    hit_xstart ? {21'h0, xstart_r} :
                    hit_xstop ? {21'h0, xstop_r} :
                    hit_ystart ? {22'h0, ystart_r} :
                    hit_status ? status_w : 32'h0;

  // ==========================================================
  // start position and stepping
  // lsb of the start column is ignored: the pointer only holds pairs
  wire logic [STG_W-1:0] start_raw = xstart_r[COL_W-1:1];
  // sub-sampling cannot start beyond half the row
  wire logic [STG_W-1:0] start_stg = (sub && start_raw > SUB_MAX_STG) ? SUB_MAX_STG : start_raw;
  wire logic [STG_W:0] step = sub ? 11'h002 : 11'h001;
  wire logic [STG_W:0] stage_adv = {1'b0, stage_r} + step;
  wire logic [COL_W:0] adv_col = {stage_adv, 1'b0};
  // stop at the window edge or at the array edge, whichever comes first
  wire logic last_pair = (adv_col > {1'b0, xstop_r}) || (adv_col > {1'b0, COL_LAST});
  // a row clock at any time aborts the row and restarts blanking
  wire logic row_go = row_clk_i;
  // blanking lasts a fixed count of system clocks
  wire logic in_calib = (state_r == ST_CALIB);
  wire logic cal_done = (cal_cnt_r == CAL_LAST);
  wire logic shift_go = (state_r == ST_SHIFT) && !row_go;

  always_comb begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    stage_nxt = stage_r;
    case (state_r)
      ST_IDLE: begin
        // pointer stays cleared until the next row clock
        state_nxt = ST_IDLE;
      end
      ST_CALIB: begin
        // pointer held empty while the amplifiers calibrate
        if (cal_done) begin
          state_nxt = ST_SYNC;
        end
      end
      ST_SYNC: begin
        // every shift path open, decoder drives the pointer
        ptr_nxt = pcca_onehot(start_stg);
        stage_nxt = start_stg;
        state_nxt = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (phase_r) begin
          if (last_pair) begin
            state_nxt = ST_IDLE;
            ptr_nxt = '0;
          end else begin
            ptr_nxt = pcca_adv_ptr(ptr_r, sub);
            stage_nxt = stage_adv[STG_W-1:0];
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (row_go) begin
      state_nxt = ST_CALIB;
      ptr_nxt = '0;
    end
  end

  // ==========================================================
  // readout sequencer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      cal_cnt_r <= 7'h00;
      ptr_r <= '0;
      stage_r <= '0;
      phase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      stage_r <= stage_nxt;
      cal_cnt_r <= (row_go || !in_calib) ? 7'h00 : cal_cnt_r + 7'h01;
      // without sub-sampling phase 0 shows the even column, phase 1 the odd one; phase 1 moves the pointer
      phase_r <= shift_go ? ~phase_r : 1'b0;
    end
  end

  // ==========================================================
  // pixel stream, one clock behind the pointer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_valid_r <= 1'b0;
      pix_col_r <= '0;
    end else begin
      pix_valid_r <= shift_go;
      pix_col_r <= pcca_map_col(stage_r, phase_r, sub, sw1, sw2);
    end
  end

  assign pixel_valid_o = pix_valid_r;
  assign pixel_col_o = pix_col_r;
  assign bus_sel_o = pix_col_r[0];

  assign calib_o = in_calib;
  assign col_sync_o = (state_r == ST_SYNC);

  // ==========================================================
  // row pointer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row_r <= '0;
    end else if (row_go && row_start_i) begin
      row_r <= ystart_r;
    end else if (row_go && row_r != ROW_LAST) begin
      // saturate on the last row rather than wrap to the top
      row_r <= row_r + 10'h001;
    end
  end
  assign row_ptr_o = row_r;

  // ==========================================================
  // shutter sequencer
  // stop wins when both strobes coincide, so a stray start never extends exposure
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      integ_r <= 1'b0;
      pix_reset_r <= 1'b0;
      pix_hold_r <= 1'b0;
    end else begin
      // reset pulses on start unless stop coincides; hold pulses only if an exposure was running
      pix_reset_r <= ss_start_i & ~ss_stop_i;
      pix_hold_r <= ss_stop_i & integ_r;
      if (ss_stop_i) begin
        integ_r <= 1'b0;
      end else if (ss_start_i) begin
        integ_r <= 1'b1;
      end
    end
  end
  assign pixel_reset_o = pix_reset_r;
  assign pixel_sample_o = integ_r;
  assign pixel_hold_o = pix_hold_r;

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
      xstart_r <= XSTART_RST;
      xstop_r <= XSTOP_RST;
      ystart_r <= YSTART_RST;
    end else if (wr) begin
      // status is read only: writes to it complete and are dropped
      if (hit_ctrl) begin
        ctrl_r <= pwdata_i[CTRL_W-1:0];
      end
      if (hit_xstart) begin
        xstart_r <= pwdata_i[COL_W-1:0];
      end
      if (hit_xstop) begin
        xstop_r <= pwdata_i[COL_W-1:0];
      end
      if (hit_ystart) begin
        ystart_r <= pwdata_i[ROW_W-1:0];
      end
    end
  end

  // level select pins follow the control register directly
  assign multislope_level_select_o = ctrl_r[CTRL_KNEE+1:CTRL_KNEE];
  assign external_reset_level_select_o = ctrl_r[CTRL_EXTRST];
  assign multislope_gen_connect_o = ~ctrl_r[CTRL_EXTRST];
endmodule

// >>> tb/pcca_ctrl_model.sv
`timescale 1ns/100ps
// ====
// camera controller: shutter and row strobes
module pcca_ctrl_model (
  input wire logic mclk_i,
  output logic ss_start_o,
  output logic ss_stop_o,
  output logic row_start_o,
  output logic row_clk_o
);
  initial begin
    {ss_start_o, ss_stop_o, row_start_o, row_clk_o} = 4'h0;
  end
  // one-cycle strobes; row start only ever rides with a row clock
  task automatic strobe(input logic [3:0] s);
    @(posedge mclk_i);
    {ss_start_o, ss_stop_o, row_start_o, row_clk_o} <= s;
    @(posedge mclk_i);
    {ss_start_o, ss_stop_o, row_start_o, row_clk_o} <= 4'h0;
  endtask
endmodule

// >>> tb/pcca_core_asserts.sv
`timescale 1ns/100ps
// ====
// port checks of the readout sequencer
module pcca_core_asserts
  import pcca_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ss_start_i,
  input wire logic ss_stop_i,
  input wire logic row_start_i,
  input wire logic row_clk_i,
  input wire logic pixel_reset_o,
  input wire logic pixel_sample_o,
  input wire logic pixel_hold_o,
  input wire logic calib_o,
  input wire logic col_sync_o,
  input wire logic pixel_valid_o,
  input wire logic [pcca_pkg::COL_W-1:0] pixel_col_o,
  input wire logic bus_sel_o,
  input wire logic [pcca_pkg::ROW_W-1:0] row_ptr_o
);
  logic [7:0] cal_cnt_r;
  // a restarted row must not inherit the old blanking count
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) cal_cnt_r <= 8'h00;
    else if (row_clk_i) cal_cnt_r <= 8'h00;
    else if (calib_o) cal_cnt_r <= cal_cnt_r + 8'h01;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_calib_start: assert property (row_clk_i |=> calib_o) else $error("no blanking after row clock");
  a_calib_len: assert property (col_sync_o |-> cal_cnt_r == 8'(CAL_CYC)) else $error("blanking length wrong");
  a_sync_single: assert property (col_sync_o && !row_clk_i |=> !col_sync_o && !calib_o)
    else $error("sync not single");
  a_first_pix: assert property (col_sync_o && !row_clk_i ##1 !row_clk_i |=> pixel_valid_o)
    else $error("first pixel late");
  a_col_rise: assert property (pixel_valid_o && !row_clk_i |=> !pixel_valid_o || pixel_col_o > $past(pixel_col_o))
    else $error("column order broken");
  a_bus_even: assert property (pixel_valid_o |-> bus_sel_o == pixel_col_o[0] && !calib_o)
    else $error("bus select wrong");
  a_shut_start: assert property (ss_start_i && !ss_stop_i |=> pixel_reset_o && pixel_sample_o)
    else $error("start strobe ignored");
  a_shut_stop: assert property (ss_stop_i && pixel_sample_o |=> pixel_hold_o && !pixel_sample_o)
    else $error("stop strobe ignored");
  a_row_step: assert property (row_clk_i && !row_start_i && row_ptr_o != ROW_LAST |=>
    row_ptr_o == $past(row_ptr_o) + 10'h001) else $error("row step wrong");
  cover property ($fell(pixel_valid_o));
  cover property (pixel_hold_o);
  cover property (row_clk_i && calib_o);
endmodule
bind pcca_core pcca_core_asserts u_chk (.mclk_i, .rst_n_i, .ss_start_i, .ss_stop_i, .row_start_i, .row_clk_i,
  .pixel_reset_o, .pixel_sample_o, .pixel_hold_o, .calib_o, .col_sync_o, .pixel_valid_o, .pixel_col_o,
  .bus_sel_o, .row_ptr_o);

// >>> tb/pixel_core_column_addressing_bench.sv
`timescale 1ns/100ps
module pixel_core_column_addressing_bench;
  import pcca_pkg::*;
  logic mclk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic ss_start_i, ss_stop_i, row_start_i, row_clk_i, pixel_reset_o, pixel_sample_o, pixel_hold_o;
  logic calib_o, col_sync_o, pixel_valid_o, bus_sel_o, external_reset_level_select_o, multislope_gen_connect_o;
  logic [COL_W-1:0] pixel_col_o;
  logic [ROW_W-1:0] row_ptr_o, rp, ys;
  logic [1:0] multislope_level_select_o;
  logic [2:0] m;
  logic [5:0] cf;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7, 3'h6};
  logic [COL_W-1:0] q[$];
  int e[$];
  int n_errors, checked, cyc, t0, first, st, sp, xs;
  pcca_core uut (.*);
  pcca_ctrl_model ctl (.mclk_i(mclk_i), .ss_start_o(ss_start_i), .ss_stop_o(ss_stop_i),
    .row_start_o(row_start_i), .row_clk_o(row_clk_i));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // ====
  // pixel monitor, cycles counted from the row clock edge
  always @(posedge mclk_i) begin
    cyc++;
    if (row_clk_i) begin
      t0 = cyc;
      q.delete();
    end
    if (pixel_valid_o) begin
      if (q.size() == 0) first = cyc;
      q.push_back(pixel_col_o);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk_i);
      if (pready_o === 1'b1) break;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (i == 16) begin
      n_errors++;
      complete_run();
    end
  endtask
  // when sub-sampling, swaps remap the pair inside each group of four columns; without it columns run in order
  function automatic void exp_row(input logic [2:0] md, input int s, input int p);
    int o0[4] = '{0, 0, 1, 2};
    int o1[4] = '{1, 2, 3, 3};
    e.delete();
    if (!md[0]) for (int c = s; c <= p; c++) e.push_back(c);
    else for (int b = s; b + 3 <= p; b += 4) begin
      e.push_back(b + o0[md[2:1]]);
      e.push_back(b + o1[md[2:1]]);
    end
  endfunction
  task automatic run_row(input logic ws, input logic ab);
    int i;
    ctl.strobe({2'b00, ws, 1'b1});
    if (ab) begin
      repeat (20) @(posedge mclk_i);
      ctl.strobe({2'b00, ws, 1'b1});
    end
    // look only after the monitor has seen the row clock and emptied the old queue
    for (i = 0; i < 3000; i++) begin
      @(negedge mclk_i);
      if (q.size() > 0 && !pixel_valid_o) break;
    end
    if (i == 3000) begin
      n_errors++;
      complete_run();
    end
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    rst_n_i = 1'b0;
    void'($urandom(32'hD73D880B));
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, (i == 2) ? 32'h4FF : 32'h0);
      chk(er, i == 5);
    end
    ctl.strobe(4'h8);
    @(negedge mclk_i);
    chk({pixel_reset_o, pixel_sample_o}, 2'b11);
    repeat (3) @(posedge mclk_i);
    ctl.strobe(4'h4);
    @(negedge mclk_i);
    chk({pixel_hold_o, pixel_sample_o}, 2'b10);
    rp = 10'h000;
    for (int k = 0; k < 6; k++) begin
      m = modes[k];
      // one sub-sampled row asks for a start past half the row
      st = (k == 4) ? 638 : 2 * ($urandom % 16);
      xs = (k == 4) ? 1000 : st;
      sp = st + 4 * (1 + $urandom % 4) - 1;
      ys = 10'($urandom % 1000);
      cf = {1'($urandom), 2'($urandom), m};
      apb(1'b1, OFS_CTRL, 32'(cf));
      apb(1'b1, OFS_XSTART, 32'(xs));
      apb(1'b1, OFS_XSTOP, 32'(sp));
      apb(1'b1, OFS_YSTART, 32'(ys));
      apb(1'b0, OFS_XSTART, 32'h0);
      chk(rd, 32'(xs));
      chk({external_reset_level_select_o, multislope_level_select_o, multislope_gen_connect_o}, {cf[5:3], ~cf[5]});
      run_row(k % 2 == 0, k == 5);
      rp = (k % 2 == 0) ? ys : rp + 10'(1 + (k == 5));
      chk(row_ptr_o, rp);
      chk(first - t0, 73);
      exp_row(m, st, sp);
      chk(q.size(), e.size());
      foreach (e[j]) chk(q[j], e[j]);
    end
    complete_run();
  end
endmodule
